/* logic/tmr_edge.sv */
// Rising-edge detector for the external count input.
// Assumes the input is already synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
module tmr_edge
   import tmr_pkg::*;
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // Level in, pulse out
   input  wire logic level_i,
   output logic      rise_o
);

   tmr_edge_type r;
   tmr_edge_type next_r;

   always_comb
   begin
      next_r.prev = level_i;
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         r <= '0;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign rise_o = level_i & ~r.prev;

endmodule
`default_nettype wire

/* logic/tmr_pkg.sv */
// Shared constants and types of the 16-bit event-reset timer.
// Assumes a 32-bit AHB-Lite slave port with word-aligned registers.
package tmr_pkg;

   // Register byte addresses (low address bits only)
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_LOW  = 8'h04;
   localparam logic [7:0] ADDR_HIGH = 8'h08;
   localparam logic [7:0] ADDR_IRQ  = 8'h0C;
   localparam logic [7:0] ADDR_CMP  = 8'h10;

   // counter_control fields
   localparam int CTRL_RUN   = 0;
   localparam int CTRL_EXT   = 1;
   localparam int CTRL_OSC   = 3;
   localparam int CTRL_PS_LO = 4;
   localparam int CTRL_WIDE  = 7;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // Interrupt register fields
   localparam int IRQ_FLAG = 0;
   localparam int IRQ_EN   = 1;

   // Compare register fields
   localparam int CMP_MODE_LO = 16;
   localparam logic [3:0]  MODE_TRIG  = 4'hB;
   localparam logic [3:0]  MODE_RESET = 4'h0;
   localparam logic [15:0] CMP_RESET  = 16'h0000;

   // Counter limits
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] COUNT_MAX  = 16'hFFFF;

   // Bus constants
   localparam logic [2:0]  HSIZE_WORD = 3'h2;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

   typedef struct packed {
      logic [15:0] count;
      logic [7:0]  hbuf;
      logic [7:0]  ctrl;
      logic        flag;
      logic        ie;
      logic [15:0] cmp;
      logic [3:0]  mode;
      logic        dp_wr;
      logic [7:0]  dp_addr;
      logic [31:0] rdata;
      logic        ready;
      logic        irq;
      logic        adc_start;
      logic        osc_out;
      logic        osc_run;
   } tmr_state_type;

   typedef struct packed {
      logic [2:0] cnt;
   } tmr_presc_type;

   typedef struct packed {
      logic prev;
   } tmr_edge_type;

endpackage

/* logic/tmr_prescale.sv */
// Prescaler dividing count events by 1, 2, 4 or 8.
// Assumes the clear has priority; one output pulse per divided event.
`timescale 1ns/1ps
`default_nettype none
module tmr_prescale
   import tmr_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Control
   input  wire logic       en_i,
   input  wire logic       clr_i,
   input  wire logic [1:0] sel_i,
   // Divided event
   output logic            tick_o
);

   tmr_presc_type r;
   tmr_presc_type next_r;
   logic [2:0]    limit;

   assign limit  = 3'((4'h1 << sel_i) - 4'h1);
   assign tick_o = en_i & (r.cnt == limit) & ~clr_i;

   always_comb
   begin
      next_r = r;
      if (clr_i)
      begin
         next_r.cnt = 3'h0;
      end
      else if (en_i)
      begin
         next_r.cnt = tick_o ? 3'h0 : 3'(r.cnt + 3'h1);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         r <= '0;
      end
      else
      begin
         r <= next_r;
      end
   end

endmodule
`default_nettype wire

/* logic/tmr_top.sv */
// 16-bit up-counter with overflow flag, buffered wide access and
// compare-driven special event reset, behind an AHB-Lite slave.
// Assumes a single master, single word transfers, one system clock.
//
// Function
// RULE1: counter pair counts up 0000h..FFFFh, then wraps to 0000h.
// RULE2: wrap latches overflow flag; interrupt only while its enable is set.
// RULE3: trigger mode 1011 match resets counter, starts conversion if converter enabled.
// RULE4: trigger reset never sets the overflow flag.
// RULE5: software uses timer or synchronized counter mode for trigger reset.
// RULE6: software write in the trigger cycle wins over the reset.
// RULE7: in trigger mode the compare value acts as counter period.
// RULE8: wide access mode maps high-byte address to a buffer.
// RULE9: wide mode low-byte read copies live high byte into buffer.
// RULE10: wide mode low-byte write also loads high byte from buffer.
// RULE11: wide mode gives no direct path to live high byte.
// RULE12: high-byte write keeps prescaler; low-byte write clears it.
// RULE13: oscillator runs only when enabled, and keeps running in sleep.
// RULE14: software waits its own start-up delay after enabling oscillator.
// RULE15: without wide mode, high-byte address reaches live high byte directly.
`timescale 1ns/1ps
`default_nettype none
module tmr_top
   import tmr_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        nrst_i,
   // AHB-Lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   // Oscillator pins and system status
   input  wire logic        aux_osc_input_i,
   input  wire logic        sleep_i,
   input  wire logic        adc_enable_i,
   output logic             aux_osc_output_o,
   output logic             aux_osc_run_o,
   // Events
   output logic             irq_o,
   output logic             adc_start_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release

   logic [1:0] rst_pipe;
   logic       rst_n;

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rst_pipe <= 2'b00;
      end
      else
      begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end

   assign rst_n = rst_pipe[1];

   ////////////////////////////////////////////////////////////////////////////
   // Decode and event sources

   tmr_state_type r;
   tmr_state_type next_r;
   logic          addr_ok;
   logic          rd_low;
   logic          wr_low;
   logic          wr_high;
   logic          wr_irq;
   logic          wide;
   logic          pin_rise;
   logic          src_evt;
   logic          tick;
   logic          trig;
   logic          wrap;

   assign addr_ok = hsel_i & htrans_i[1] & hready_i & (hsize_i == HSIZE_WORD);
   assign rd_low  = addr_ok & ~hwrite_i & (haddr_i[7:0] == ADDR_LOW);
   assign wr_low  = r.dp_wr & (r.dp_addr == ADDR_LOW);
   assign wr_high = r.dp_wr & (r.dp_addr == ADDR_HIGH);
   assign wr_irq  = r.dp_wr & (r.dp_addr == ADDR_IRQ);
   assign wide    = r.ctrl[CTRL_WIDE];

   // System clock source halts in sleep; the pin source does not
   assign src_evt = r.ctrl[CTRL_RUN] & (r.ctrl[CTRL_EXT] ? pin_rise : ~sleep_i);

   assign trig = tick & (r.mode == MODE_TRIG) & (r.count == r.cmp); // [RULE3] [RULE7]
   assign wrap = tick & ~trig & (r.count == COUNT_MAX); // [RULE1]

   tmr_edge u_edge (
      .clk_i   (clk_sys_i),
      .rst_n_i (rst_n),
      .level_i (aux_osc_input_i),
      .rise_o  (pin_rise)
   );

   // Only the low-byte write clears the prescaler
   tmr_prescale u_presc (
      .clk_i   (clk_sys_i),
      .rst_n_i (rst_n),
      .en_i    (src_evt),
      .clr_i   (wr_low), // [RULE12]
      .sel_i   (r.ctrl[CTRL_PS_LO+1:CTRL_PS_LO]),
      .tick_o  (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      next_r       = r;
      next_r.ready = 1'b1;
      next_r.dp_wr = addr_ok & hwrite_i;
      if (addr_ok)
      begin
         next_r.dp_addr = haddr_i[7:0];
      end

      // Count; a write in the same cycle overrides both tick and trigger
      if (wr_low)
      begin
         next_r.count[7:0] = hwdata_i[7:0];
         if (wide)
         begin
            next_r.count[15:8] = r.hbuf; // [RULE10] [RULE6]
         end
      end
      else if (wr_high && !wide)
      begin
         next_r.count[15:8] = hwdata_i[7:0]; // [RULE15] [RULE6]
      end
      else if (trig)
      begin
         next_r.count = COUNT_ZERO; // [RULE3] [RULE7]
      end
      else if (tick)
      begin
         next_r.count = 16'(r.count + 16'h0001); // [RULE1]
      end

      if (wr_high && wide)
      begin
         next_r.hbuf = hwdata_i[7:0]; // [RULE8] [RULE11]
      end
      if (rd_low && wide)
      begin
         next_r.hbuf = r.count[15:8]; // [RULE9]
      end

      if (r.dp_wr && r.dp_addr == ADDR_CTRL)
      begin
         next_r.ctrl = hwdata_i[7:0];
      end
      if (r.dp_wr && r.dp_addr == ADDR_CMP)
      begin
         next_r.cmp  = hwdata_i[15:0];
         next_r.mode = hwdata_i[CMP_MODE_LO+3:CMP_MODE_LO];
      end

      // Flag is write-one-to-clear; a wrap in the same cycle wins
      if (wr_irq)
      begin
         next_r.ie = hwdata_i[IRQ_EN];
         if (hwdata_i[IRQ_FLAG])
         begin
            next_r.flag = 1'b0;
         end
      end
      if (wrap)
      begin
         next_r.flag = 1'b1; // [RULE2] [RULE4]
      end

      next_r.irq       = r.flag & r.ie; // [RULE2]
      next_r.adc_start = trig & adc_enable_i; // [RULE3]
      next_r.osc_run   = r.ctrl[CTRL_OSC]; // [RULE13]
      next_r.osc_out   = r.ctrl[CTRL_OSC] & ~aux_osc_input_i; // [RULE13]

      // Read data is captured in the address phase
      next_r.rdata = RDATA_ZERO;
      if (addr_ok && !hwrite_i)
      begin
         case (haddr_i[7:0])
            ADDR_CTRL: next_r.rdata[7:0] = r.ctrl;
            ADDR_LOW:  next_r.rdata[7:0] = r.count[7:0];
            ADDR_HIGH: next_r.rdata[7:0] = wide ? r.hbuf : r.count[15:8]; // [RULE11] [RULE15]
            ADDR_IRQ:  next_r.rdata[1:0] = {r.ie, r.flag};
            ADDR_CMP:  next_r.rdata[19:0] = {r.mode, r.cmp};
            default:   next_r.rdata = RDATA_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         r      <= '0;
         r.ctrl <= CTRL_RESET;
         r.cmp  <= CMP_RESET;
         r.mode <= MODE_RESET;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign hrdata_o         = r.rdata;
   assign hreadyout_o      = r.ready;
   assign hresp_o          = 1'b0;
   assign irq_o            = r.irq;
   assign adc_start_o      = r.adc_start;
   assign aux_osc_output_o = r.osc_out;
   assign aux_osc_run_o    = r.osc_run;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n);

   sequence s_trig_only;
      trig && !wr_low && !wr_high;
   endsequence

   sequence s_rd_low_wide;
      rd_low && wide && !wr_high;
   endsequence

   // Conversion start is registered, so it lines up with the cleared count
   sequence s_trig_result;
      r.count == COUNT_ZERO && adc_start_o == $past(adc_enable_i);
   endsequence

   a_wrap_to_zero: assert property (wrap && !r.dp_wr |=> r.count == COUNT_ZERO && r.flag) // [RULE1]
      else $error("counter did not wrap to zero with flag");

   a_irq_gated: assert property (##1 irq_o == ($past(r.flag) && $past(r.ie))) // [RULE2]
      else $error("interrupt output does not follow flag and enable");

   a_trig_reset: assert property (s_trig_only |=> s_trig_result) // [RULE3]
      else $error("trigger did not reset counter or start conversion");

   a_trig_no_flag: assert property (s_trig_only and (!r.flag && !wrap) |=> !r.flag) // [RULE4]
      else $error("trigger reset set the overflow flag");

   a_write_wins: assert property (trig && wr_low |=> r.count[7:0] == $past(hwdata_i[7:0])) // [RULE6]
      else $error("trigger overrode a counter write");

   a_period_cmp: assert property (tick && r.mode == MODE_TRIG && r.count == r.cmp && !r.dp_wr // [RULE7]
                                  |=> r.count == COUNT_ZERO)
      else $error("compare value not used as period");

   a_hbuf_load: assert property (s_rd_low_wide |=> r.hbuf == $past(r.count[15:8])) // [RULE9]
      else $error("low read did not latch high byte");

   a_wide_write: assert property (wr_low && wide |=> r.count[15:8] == $past(r.hbuf)) // [RULE10]
      else $error("wide write did not load high byte from buffer");

   a_high_redirect: assert property (addr_ok && !hwrite_i && haddr_i[7:0] == ADDR_HIGH && wide // [RULE8]
                                     |=> hrdata_o[7:0] == $past(r.hbuf))
      else $error("high read in wide mode bypassed buffer");

   a_high_direct: assert property (wr_high && wide && !wr_low && !tick |=> r.count == $past(r.count)) // [RULE11]
      else $error("wide high write reached live counter");

   a_osc_run: assert property (##1 aux_osc_run_o == $past(r.ctrl[CTRL_OSC])) // [RULE13]
      else $error("oscillator run does not follow its enable");

   a_osc_quiet: assert property (!r.ctrl[CTRL_OSC] |=> !aux_osc_output_o) // [RULE13]
      else $error("oscillator output moved while disabled");

   a_count_step: assert property (tick && !trig && !r.dp_wr |=> r.count == 16'($past(r.count) + 16'h0001)) // [RULE1]
      else $error("counter did not advance by one on a tick");

   a_irq_masked: assert property (!r.ie |=> !irq_o) // [RULE2]
      else $error("interrupt raised while disabled");

   a_flag_source: assert property (!r.flag && !wrap |=> !r.flag) // [RULE4]
      else $error("overflow flag set without a wrap");

   a_adc_only_trig: assert property (!trig |=> !adc_start_o) // [RULE3]
      else $error("conversion started without a trigger");

   // A direct high write keeps the low byte; the trigger reset is dropped
   a_high_wins: assert property (trig && wr_high && !wide // [RULE6]
                                 |=> r.count == {$past(hwdata_i[7:0]), $past(r.count[7:0])})
      else $error("trigger overrode a high byte write");

   a_presc_clear: assert property (wr_low |=> u_presc.r.cnt == 3'h0) // [RULE12]
      else $error("low write did not clear prescaler");

   a_presc_keep: assert property (wr_high && src_evt && !tick // [RULE12]
                                  |=> u_presc.r.cnt == 3'($past(u_presc.r.cnt) + 3'h1))
      else $error("high write disturbed prescaler");

endmodule
`default_nettype wire

/* tb/testbench.sv */
// Bus-level tests of the event-reset timer.
// Assumes zero-wait AHB-Lite slave and the crystal model on the pins.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import tmr_pkg::*;
   logic        clk_sys_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic        hready;
   logic        hresp;
   logic        pin;
   logic        sleep = 1'b0;
   logic        adc_en = 1'b0;
   logic        osc_out;
   logic        osc_run;
   logic        irq;
   logic        adc_start;
   logic        osc_q = 1'b0;
   int          err_count = 0;
   int          total_checks = 0;
   int          adc_cnt = 0;
   int          osc_cnt = 0;
   logic [31:0] d;
   int          n;

   always #10 clk_sys_i = ~clk_sys_i;

   tmr_top uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .hsel_i(1'b1), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(HSIZE_WORD), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .aux_osc_input_i(pin), .sleep_i(sleep), .adc_enable_i(adc_en),
      .aux_osc_output_o(osc_out), .aux_osc_run_o(osc_run), .irq_o(irq),
      .adc_start_o(adc_start));

   tmr_osc_model osc (.clk_i(clk_sys_i), .run_i(osc_run), .pin_o(pin));

   // Pulse counters update after the edge, so readers never race them
   always @(posedge clk_sys_i)
   begin
      osc_q <= osc_out;
      if (osc_out === 1'b1 && osc_q === 1'b0) osc_cnt <= osc_cnt + 1;
      if (adc_start === 1'b1) adc_cnt <= adc_cnt + 1;
   end

   ////////////////////////////////////////////////////////////////////
   task tally_and_finish;
      if (err_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task chk(input logic ok, input string m);
      total_checks++;
      if (ok !== 1'b1)
      begin
         err_count++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask

   task wait_rdy;
      do
      begin
         @(posedge clk_sys_i);
      end while (hready !== 1'b1);
   endtask

   task wr(input logic [7:0] a, input logic [31:0] v);
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= 1'b1;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= v;
      wait_rdy();
   endtask

   task rd(input logic [7:0] a, output logic [31:0] v);
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= 1'b0;
      wait_rdy();
      htrans <= 2'h0;
      wait_rdy();
      v = hrdata;
   endtask

   task rdc(input logic [7:0] a, input logic [31:0] e, input string m);
      logic [31:0] v;
      rd(a, v);
      chk(v === e, m);
   endtask

   ////////////////////////////////////////////////////////////////////
   initial
   begin
      #100us;
      err_count++;
      tally_and_finish();
   end

   initial
   begin
      repeat (4) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      rdc(ADDR_CTRL, {24'h00_0000, CTRL_RESET}, "ctrl reset value");
      rdc(ADDR_CMP, 32'h0000_0000, "compare reset value");
      rdc(8'h20, RDATA_ZERO, "unmapped read");
      chk(hresp === 1'b0, "response not OKAY");
      // Wrap to zero in timer mode, then overflow flag and interrupt enable
      wr(ADDR_LOW, 32'h0000_00FF);
      wr(ADDR_HIGH, 32'h0000_00FF);
      wr(ADDR_CTRL, 32'h0000_0001);
      wr(ADDR_CTRL, 32'h0000_0000);
      rdc(ADDR_HIGH, 32'h0000_0000, "wrap to zero");
      rdc(ADDR_IRQ, 32'h0000_0001, "flag after wrap");
      chk(irq === 1'b0, "irq while masked");
      wr(ADDR_IRQ, 32'h0000_0002);
      rdc(ADDR_IRQ, 32'h0000_0003, "flag kept on enable");
      chk(irq === 1'b1, "irq when enabled");
      wr(ADDR_IRQ, 32'h0000_0001);
      rdc(ADDR_IRQ, 32'h0000_0000, "flag cleared");
      chk(irq === 1'b0, "irq after clear");
      // Wide access through the high-byte buffer
      wr(ADDR_CTRL, 32'h0000_0080);
      wr(ADDR_HIGH, 32'h0000_0012);
      wr(ADDR_LOW, 32'h0000_0034);
      rdc(ADDR_LOW, 32'h0000_0034, "wide low");
      rdc(ADDR_HIGH, 32'h0000_0012, "wide high");
      wr(ADDR_HIGH, 32'h0000_0056);
      wr(ADDR_CTRL, 32'h0000_0000);
      rdc(ADDR_HIGH, 32'h0000_0012, "live high untouched");
      wr(ADDR_HIGH, 32'h0000_0077);
      rdc(ADDR_HIGH, 32'h0000_0077, "direct high");
      wr(ADDR_CTRL, 32'h0000_0080);
      rdc(ADDR_LOW, 32'h0000_0034, "low keeps value");
      rdc(ADDR_HIGH, 32'h0000_0077, "buffer latched");
      // Prescale by 8: high-byte writes must not restart it
      wr(ADDR_CTRL, 32'h0000_00B1);
      wr(ADDR_HIGH, 32'h0000_0000);
      wr(ADDR_LOW, 32'h0000_0000);
      repeat (4) wr(ADDR_HIGH, 32'h0000_0000);
      rdc(ADDR_LOW, 32'h0000_0001, "high write cleared prescaler");
      // Special event trigger as period
      wr(ADDR_CTRL, 32'h0000_0000);
      wr(ADDR_LOW, 32'h0000_0000);
      wr(ADDR_HIGH, 32'h0000_0000);
      wr(ADDR_CMP, {12'h000, MODE_TRIG, 16'h0005});
      adc_en <= 1'b1;
      wr(ADDR_CTRL, 32'h0000_0001);
      repeat (60) @(posedge clk_sys_i);
      wr(ADDR_CTRL, 32'h0000_0000);
      rd(ADDR_LOW, d);
      chk(d <= 32'h0000_0005, "count within period");
      rdc(ADDR_HIGH, 32'h0000_0000, "high stays zero");
      rdc(ADDR_IRQ, 32'h0000_0000, "no flag on trigger");
      chk(adc_cnt >= 8, "conversion starts");
      adc_en <= 1'b0;
      n = adc_cnt;
      wr(ADDR_CTRL, 32'h0000_0001);
      repeat (30) @(posedge clk_sys_i);
      wr(ADDR_CTRL, 32'h0000_0000);
      chk(adc_cnt == n, "no start when converter off");
      // Direct high write lands on the trigger edge and keeps the count
      wr(ADDR_CTRL, 32'h0000_0001);
      wr(ADDR_LOW, 32'h0000_0000);
      repeat (4) @(posedge clk_sys_i);
      wr(ADDR_HIGH, 32'h0000_0000);
      wr(ADDR_CTRL, 32'h0000_0000);
      rdc(ADDR_LOW, 32'h0000_0001, "trigger beat a counter write");
      wr(ADDR_CMP, {12'h000, MODE_RESET, 16'h0005});
      wr(ADDR_CTRL, 32'h0000_0001);
      repeat (30) @(posedge clk_sys_i);
      wr(ADDR_CTRL, 32'h0000_0000);
      rd(ADDR_LOW, d);
      chk(d > 32'h0000_0005, "no reset outside trigger mode");
      // Oscillator and pin counting survive sleep
      sleep <= 1'b1;
      wr(ADDR_LOW, 32'h0000_0000);
      wr(ADDR_CTRL, 32'h0000_000B);
      repeat (20) @(posedge clk_sys_i);
      chk(osc_run === 1'b1, "oscillator on in sleep");
      n = osc_cnt;
      repeat (40) @(posedge clk_sys_i);
      chk(osc_cnt > n, "oscillator swings");
      wr(ADDR_CTRL, 32'h0000_0000);
      sleep <= 1'b0;
      rd(ADDR_LOW, d);
      chk(d >= 32'h0000_000A && d <= 32'h0000_0014, "pin edges not counted in sleep");
      repeat (3) @(posedge clk_sys_i);
      chk(osc_run === 1'b0, "oscillator off");
      tally_and_finish();
   end
endmodule
`default_nettype wire

/* tb/tmr_osc_model.sv */
// Crystal stand-in for the auxiliary oscillator pins.
// Assumes run_i follows the oscillator enable; the pin is still when off.
`timescale 1ns/1ps
`default_nettype none
module tmr_osc_model
(
   // Clock and drive
   input  wire logic clk_i,
   input  wire logic run_i,
   // Pin toward the block
   output logic      pin_o
);
   logic [1:0] div = 2'h0;
   // Crystal only swings while its amplifier is enabled
   always @(posedge clk_i)
   begin
      if (run_i) div <= div + 2'h1;
   end
   assign pin_o = div[1];
endmodule
`default_nettype wire
